// File: src/mbc_pkg.sv
// Notes on behaviour
// - host seeds block address; device advances it
// - run blocks until end-of-list
// - bad RT response sets bit 15
// - bit 14 skips the block's message
// - bit 13 standard interrupt when enabled
// - bit 12 enables status polling compare
// - bit 11 enables retry
// - bit 10 finishes message, halts, high irq
// - bit 9 marks RT-to-RT transfer
// - bit 8 stores monitored RT-to-RT data
// - delay field in 16 us units
// - keep minimum intermessage gap
// - skipped block waits programmed delay
// - skipped block raises its interrupts
// - block word zero is never accessed
// - status one to word five, two six
// - poll mask match raises poll irq
// - check address, time-out, format, blocks
// - start bit then burst block read
// - BC-to-RT sends data words
// - RT-to-BC stores status, then data
// - RT-to-RT sends both commands
// - tail read only without retry
package mbc_pkg;
  // timing
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned DELAY_UNIT_NS = 16000;
  localparam int unsigned MIN_GAP_NS = 4000;
  localparam int unsigned RESP_TIMEOUT_NS = 14000;
  localparam int unsigned DELAY_UNIT_CYC = (DELAY_UNIT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MIN_GAP_CYC = (MIN_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RESP_TIMEOUT_CYC = (RESP_TIMEOUT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TMR_W = 10;

  // host register indices
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CUR_BLK = 4'h5;
  localparam logic [3:0] REG_HP_EN = 4'h7;
  localparam logic [3:0] REG_STD_EN = 4'h9;
  localparam logic [3:0] REG_POLL_MASK = 4'hB;
  localparam logic [3:0] REG_STATUS = 4'hC;

  // control register
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_RETRY_LSB = 1;
  localparam int unsigned CTRL_RETRY_ALT_BIT = 3;
  localparam logic [15:0] CTRL_WR_MASK = 16'h000E;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CUR_BLK_RESET = 16'h0000;
  localparam logic [15:0] EN_RESET = 16'h0000;
  localparam logic [15:0] POLL_MASK_RESET = 16'h0000;
  localparam int unsigned STDEN_IC_BIT = 0;
  localparam int unsigned STDEN_POLL_BIT = 1;
  localparam int unsigned HPEN_EOL_BIT = 0;

  // block control word fields
  localparam int unsigned CW_MSG_ERR_BIT = 15;
  localparam int unsigned CW_SKIP_BIT = 14;
  localparam int unsigned CW_IRQ_CONT_BIT = 13;
  localparam int unsigned CW_POLL_BIT = 12;
  localparam int unsigned CW_RETRY_BIT = 11;
  localparam int unsigned CW_EOL_BIT = 10;
  localparam int unsigned CW_RTRT_BIT = 9;
  localparam int unsigned CW_MONITOR_BIT = 8;
  localparam int unsigned CW_DELAY_LSB = 0;
  localparam int unsigned CW_DELAY_W = 8;

  // block word offsets; word zero is host-only
  localparam logic [15:0] BLK_CTL = 16'h0001;
  localparam logic [15:0] BLK_CMD1 = 16'h0002;
  localparam logic [15:0] BLK_CMD2 = 16'h0003;
  localparam logic [15:0] BLK_DPTR = 16'h0004;
  localparam logic [15:0] BLK_STS1 = 16'h0005;
  localparam logic [15:0] BLK_STS2 = 16'h0006;
  localparam logic [15:0] BLK_TAIL = 16'h0007;

  // 1553 word fields
  localparam int unsigned CMD_TX_BIT = 10;
  localparam int unsigned RT_ADDR_LSB = 11;
  localparam int unsigned STS_ME_BIT = 10;
  localparam int unsigned STS_BUSY_BIT = 3;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00000, S_FETCH_CTL = 5'b00001, S_FETCH_CW1 = 5'b00010,
    S_FETCH_DP = 5'b00011, S_ADDRESSED = 5'b00100, S_TX_CW1 = 5'b00101,
    S_RD_DATA = 5'b00110, S_TX_DATA = 5'b00111, S_FETCH_CW2 = 5'b01000,
    S_TX_CW2 = 5'b01001, S_RX_ST1 = 5'b01010, S_WR_ST1 = 5'b01011,
    S_RX_DATA = 5'b01100, S_WR_DATA = 5'b01101, S_RX_ST2 = 5'b01110,
    S_WR_ST2 = 5'b01111, S_END = 5'b10000, S_WR_ME = 5'b10001,
    S_DECIDE = 5'b10010, S_FETCH_TAIL = 5'b10011, S_WAIT = 5'b10100,
    S_WAIT_GAP = 5'b10101
  } mbc_state_t;

  // word count, zero means thirty-two
  function automatic logic [5:0] mbc_word_count(input logic [15:0] cmd);
    mbc_word_count = (cmd[4:0] == 5'h00) ? 6'h20 : {1'b0, cmd[4:0]};
  endfunction : mbc_word_count

  function automatic logic [4:0] mbc_rt_addr(input logic [15:0] w);
    mbc_rt_addr = w[RT_ADDR_LSB +: 5];
  endfunction : mbc_rt_addr
endpackage : mbc_pkg

// File: src/mbc_delay_timer.sv
`timescale 1ns/1ps
module mbc_delay_timer import mbc_pkg::*; #(
  parameter int unsigned UNIT_CYC = DELAY_UNIT_CYC,
  parameter int unsigned GAP_CYC = MIN_GAP_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // control
  input wire logic msg_start,
  input wire logic msg_end,
  input wire logic [7:0] delay,
  // status
  output logic gap_done,
  output logic ready
);
  logic [7:0] units_reg;
  logic [TMR_W-1:0] unit_cnt_reg;
  logic [TMR_W-1:0] gap_cnt_reg;

  // start-to-start delay, zero disables
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      units_reg <= 8'h00;
      unit_cnt_reg <= '0;
    end else if (ce) begin
      if (msg_start) begin
        units_reg <= delay;
        unit_cnt_reg <= '0;
      end else if (units_reg != 8'h00) begin
        if (unit_cnt_reg == TMR_W'(UNIT_CYC - 1)) begin
          unit_cnt_reg <= '0;
          units_reg <= units_reg - 8'h01;
        end else begin
          unit_cnt_reg <= unit_cnt_reg + TMR_W'(1);
        end
      end
    end
  end

  // minimum gap after every message
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gap_cnt_reg <= '0;
    end else if (ce) begin
      if (msg_end) begin
        gap_cnt_reg <= TMR_W'(GAP_CYC);
      end else if (gap_cnt_reg != '0) begin
        gap_cnt_reg <= gap_cnt_reg - TMR_W'(1);
      end
    end
  end

  assign gap_done = (gap_cnt_reg == '0) && !msg_end;
  assign ready = gap_done && (units_reg == 8'h00) && !msg_start;
endmodule : mbc_delay_timer

// File: src/mbc_sequencer.sv
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module mbc_sequencer import mbc_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // host register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // dma master
  output logic dma_req,
  output logic dma_we,
  output logic dma_burst,
  output logic [15:0] dma_addr,
  output logic [15:0] dma_wdata,
  input wire logic dma_ack,
  input wire logic [15:0] dma_rdata,
  // 1553 encoder
  output logic tx_valid,
  output logic tx_is_cmd,
  output logic [15:0] tx_word,
  input wire logic tx_done,
  output logic bus_select,
  // 1553 decoder
  input wire logic rx_valid,
  input wire logic [15:0] rx_word,
  input wire logic rx_is_status,
  input wire logic rx_error,
  // interrupts
  output logic standard_irq_n,
  output logic high_priority_irq_n
);
  mbc_state_t st_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] cur_blk_reg;
  logic [15:0] hp_en_reg;
  logic [15:0] std_en_reg;
  logic [15:0] poll_match_mask;
  logic [15:0] rdata_reg;
  logic halted_reg;
  logic poll_hit_reg;
  logic [15:0] ctl_reg;
  logic [15:0] cw1_reg;
  logic [15:0] cw2_reg;
  logic [15:0] dp_reg;
  logic [15:0] hold_reg;
  logic [5:0] idx_reg;
  logic [5:0] wc_reg;
  logic err_reg;
  logic busy_reg;
  logic [2:0] tries_reg;
  logic bus_sel_reg;
  logic [TMR_W-1:0] rsp_cnt_reg;
  logic std_irq_reg;
  logic hp_irq_reg;
  logic start_req;
  logic tail_load;
  logic last_word;
  logic rtrt;
  logic store_data;
  logic rsp_timeout;
  logic rx_wait;
  logic [15:0] exp_cmd;
  logic sts_bad;
  logic rtrt_bad;
  logic retry_go;
  logic poll_now;
  logic tmr_start;
  logic tmr_end;
  logic tmr_gap_done;
  logic tmr_ready;

  // block options
  assign rtrt = ctl_reg[CW_RTRT_BIT];
  assign store_data = !rtrt || ctl_reg[CW_MONITOR_BIT];
  assign last_word = ((idx_reg + 6'h01) == wc_reg);
  assign start_req = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_START_BIT];
  assign tail_load = ce && (st_reg == S_FETCH_TAIL) && dma_ack;

  // status one from transmitter, two from receiver
  assign exp_cmd = (st_reg == S_RX_ST1 && rtrt) ? cw2_reg : cw1_reg;
  assign sts_bad = rx_error || !rx_is_status || rx_word[STS_ME_BIT] ||
                   (mbc_rt_addr(rx_word) != mbc_rt_addr(exp_cmd));
  // rt-rt needs receive then transmit, to two rts
  assign rtrt_bad = cw1_reg[CMD_TX_BIT] || !dma_rdata[CMD_TX_BIT] ||
                    (mbc_word_count(dma_rdata) != mbc_word_count(cw1_reg)) ||
                    (mbc_rt_addr(dma_rdata) == mbc_rt_addr(cw1_reg));
  // one to four retries
  assign retry_go = ctl_reg[CW_RETRY_BIT] && (err_reg || busy_reg) &&
                    (tries_reg <= {1'b0, ctrl_reg[CTRL_RETRY_LSB +: 2]});
  assign poll_now = ((st_reg == S_WR_ST1) || (st_reg == S_WR_ST2)) && dma_ack &&
                    ctl_reg[CW_POLL_BIT] && ((hold_reg & poll_match_mask) != 16'h0000);

  // no timer restart on retry, so the delay spans every attempt
  assign tmr_start = (st_reg == S_ADDRESSED) && (tries_reg == 3'h0);
  assign tmr_end = (st_reg == S_END);

  mbc_delay_timer #(
    .UNIT_CYC(DELAY_UNIT_CYC),
    .GAP_CYC(MIN_GAP_CYC)
  ) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .msg_start(tmr_start),
    .msg_end(tmr_end),
    .delay(ctl_reg[CW_DELAY_LSB +: CW_DELAY_W]),
    .gap_done(tmr_gap_done),
    .ready(tmr_ready)
  );

  // response time-out
  assign rx_wait = (st_reg == S_RX_ST1) || (st_reg == S_RX_ST2) || (st_reg == S_RX_DATA);
  assign rsp_timeout = (rsp_cnt_reg == TMR_W'(RESP_TIMEOUT_CYC - 1));
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rsp_cnt_reg <= '0;
    end else if (ce) begin
      if (!rx_wait || rx_valid || rsp_timeout) begin
        rsp_cnt_reg <= '0;
      end else begin
        rsp_cnt_reg <= rsp_cnt_reg + TMR_W'(1);
      end
    end
  end

  // dma requests; block word zero never addressed
  always_comb begin
    dma_req = 1'b0;
    dma_we = 1'b0;
    dma_burst = 1'b0;
    dma_addr = cur_blk_reg + BLK_CTL;
    dma_wdata = hold_reg;
    case (st_reg)
      S_FETCH_CTL: begin
        dma_req = ce;
        dma_burst = 1'b1;
      end
      S_FETCH_CW1: begin
        dma_req = ce;
        dma_burst = 1'b1;
        dma_addr = cur_blk_reg + BLK_CMD1;
      end
      S_FETCH_DP: begin
        dma_req = ce;
        dma_burst = 1'b1;
        dma_addr = cur_blk_reg + BLK_DPTR;
      end
      S_RD_DATA: begin
        dma_req = ce;
        dma_addr = dp_reg + {10'h000, idx_reg};
      end
      S_FETCH_CW2: begin
        dma_req = ce;
        dma_addr = cur_blk_reg + BLK_CMD2;
      end
      S_WR_ST1: begin
        dma_req = ce;
        dma_we = 1'b1;
        dma_addr = cur_blk_reg + BLK_STS1;
      end
      S_WR_DATA: begin
        dma_req = ce;
        dma_we = 1'b1;
        dma_addr = dp_reg + {10'h000, idx_reg};
      end
      S_WR_ST2: begin
        dma_req = ce;
        dma_we = 1'b1;
        dma_addr = cur_blk_reg + BLK_STS2;
      end
      S_WR_ME: begin
        dma_req = ce;
        dma_we = 1'b1;
        dma_burst = 1'b1;
        dma_wdata = ctl_reg | (16'h0001 << CW_MSG_ERR_BIT);
      end
      S_FETCH_TAIL: begin
        dma_req = ce;
        dma_burst = 1'b1;
        dma_addr = cur_blk_reg + BLK_TAIL;
      end
      default: ;
    endcase
  end

  // encoder feed
  always_comb begin
    tx_valid = 1'b0;
    tx_is_cmd = 1'b0;
    tx_word = hold_reg;
    case (st_reg)
      S_TX_CW1: begin
        tx_valid = ce && tmr_gap_done;
        tx_is_cmd = 1'b1;
        tx_word = cw1_reg;
      end
      S_TX_CW2: begin
        tx_valid = ce;
        tx_is_cmd = 1'b1;
        tx_word = cw2_reg;
      end
      S_TX_DATA: tx_valid = ce;
      default: ;
    endcase
  end
  assign bus_select = bus_sel_reg;

  // block sequencer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg <= S_IDLE;
      ctl_reg <= 16'h0000;
      cw1_reg <= 16'h0000;
      cw2_reg <= 16'h0000;
      dp_reg <= 16'h0000;
      hold_reg <= 16'h0000;
      idx_reg <= 6'h00;
      wc_reg <= 6'h00;
      err_reg <= 1'b0;
      busy_reg <= 1'b0;
      tries_reg <= 3'h0;
      bus_sel_reg <= 1'b0;
    end else if (ce) begin
      case (st_reg)
        S_IDLE: begin
          if (start_req) begin
            tries_reg <= 3'h0;
            st_reg <= S_FETCH_CTL;
          end
        end
        S_FETCH_CTL: begin
          if (dma_ack) begin
            ctl_reg <= dma_rdata;
            st_reg <= S_FETCH_CW1;
          end
        end
        S_FETCH_CW1: begin
          if (dma_ack) begin
            cw1_reg <= dma_rdata;
            st_reg <= S_FETCH_DP;
          end
        end
        S_FETCH_DP: begin
          if (dma_ack) begin
            dp_reg <= dma_rdata;
            st_reg <= S_ADDRESSED;
          end
        end
        S_ADDRESSED: begin
          idx_reg <= 6'h00;
          err_reg <= 1'b0;
          busy_reg <= 1'b0;
          wc_reg <= mbc_word_count(cw1_reg);
          st_reg <= ctl_reg[CW_SKIP_BIT] ? S_DECIDE : S_TX_CW1;
        end
        S_TX_CW1: begin
          if (tx_done) begin
            if (rtrt) begin
              st_reg <= S_FETCH_CW2;
            end else if (cw1_reg[CMD_TX_BIT]) begin
              st_reg <= S_RX_ST1;
            end else begin
              st_reg <= S_RD_DATA;
            end
          end
        end
        S_RD_DATA: begin
          if (dma_ack) begin
            hold_reg <= dma_rdata;
            st_reg <= S_TX_DATA;
          end
        end
        S_TX_DATA: begin
          if (tx_done) begin
            idx_reg <= idx_reg + 6'h01;
            st_reg <= last_word ? S_RX_ST1 : S_RD_DATA;
          end
        end
        S_FETCH_CW2: begin
          if (dma_ack) begin
            cw2_reg <= dma_rdata;
            wc_reg <= mbc_word_count(dma_rdata);
            err_reg <= rtrt_bad;
            st_reg <= rtrt_bad ? S_END : S_TX_CW2;
          end
        end
        S_TX_CW2: begin
          if (tx_done) begin
            st_reg <= S_RX_ST1;
          end
        end
        S_RX_ST1, S_RX_ST2: begin
          if (rx_valid) begin
            hold_reg <= rx_word;
            err_reg <= err_reg || sts_bad;
            busy_reg <= busy_reg || rx_word[STS_BUSY_BIT];
            st_reg <= (st_reg == S_RX_ST1) ? S_WR_ST1 : S_WR_ST2;
          end else if (rsp_timeout) begin
            err_reg <= 1'b1;
            st_reg <= S_END;
          end
        end
        S_WR_ST1: begin
          if (dma_ack) begin
            if (err_reg || (!rtrt && !cw1_reg[CMD_TX_BIT])) begin
              st_reg <= S_END;
            end else begin
              st_reg <= S_RX_DATA;
            end
          end
        end
        S_RX_DATA: begin
          if (rx_valid) begin
            hold_reg <= rx_word;
            if (rx_error || rx_is_status) begin
              err_reg <= 1'b1;
              st_reg <= S_END;
            end else if (store_data) begin
              st_reg <= S_WR_DATA;
            end else begin
              idx_reg <= idx_reg + 6'h01;
              st_reg <= last_word ? S_RX_ST2 : S_RX_DATA;
            end
          end else if (rsp_timeout) begin
            err_reg <= 1'b1;
            st_reg <= S_END;
          end
        end
        S_WR_DATA: begin
          if (dma_ack) begin
            idx_reg <= idx_reg + 6'h01;
            if (!last_word) begin
              st_reg <= S_RX_DATA;
            end else begin
              st_reg <= rtrt ? S_RX_ST2 : S_END;
            end
          end
        end
        S_WR_ST2: begin
          if (dma_ack) begin
            st_reg <= S_END;
          end
        end
        S_END: st_reg <= err_reg ? S_WR_ME : S_DECIDE;
        S_WR_ME: begin
          if (dma_ack) begin
            st_reg <= S_DECIDE;
          end
        end
        S_DECIDE: begin
          if (retry_go) begin
            tries_reg <= tries_reg + 3'h1;
            if (ctrl_reg[CTRL_RETRY_ALT_BIT]) begin
              bus_sel_reg <= !bus_sel_reg;
            end
            st_reg <= S_WAIT_GAP;
          end else if (ctl_reg[CW_EOL_BIT]) begin
            st_reg <= S_IDLE;
          end else begin
            st_reg <= S_FETCH_TAIL;
          end
        end
        S_FETCH_TAIL: begin
          if (dma_ack) begin
            tries_reg <= 3'h0;
            st_reg <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (tmr_ready) begin
            st_reg <= S_FETCH_CTL;
          end
        end
        S_WAIT_GAP: begin
          if (tmr_gap_done) begin
            st_reg <= S_FETCH_CTL;
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  // one-cycle irq pulses, skips included
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      std_irq_reg <= 1'b0;
      hp_irq_reg <= 1'b0;
    end else if (ce) begin
      std_irq_reg <= ((st_reg == S_ADDRESSED) && ctl_reg[CW_IRQ_CONT_BIT] &&
                      std_en_reg[STDEN_IC_BIT]) ||
                     (poll_now && std_en_reg[STDEN_POLL_BIT]);
      hp_irq_reg <= (st_reg == S_DECIDE) && !retry_go && ctl_reg[CW_EOL_BIT] &&
                    hp_en_reg[HPEN_EOL_BIT];
    end
  end
  assign standard_irq_n = !std_irq_reg;
  assign high_priority_irq_n = !hp_irq_reg;

  // host registers; tail load beats a host write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
      cur_blk_reg <= CUR_BLK_RESET;
      hp_en_reg <= EN_RESET;
      std_en_reg <= EN_RESET;
      poll_match_mask <= POLL_MASK_RESET;
    end else if (ce) begin
      if (reg_wr && reg_addr == REG_CTRL) begin
        ctrl_reg <= reg_wdata & CTRL_WR_MASK;
      end
      if (tail_load) begin
        cur_blk_reg <= dma_rdata;
      end else if (reg_wr && reg_addr == REG_CUR_BLK && st_reg == S_IDLE) begin
        cur_blk_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == REG_HP_EN) begin
        hp_en_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == REG_STD_EN) begin
        std_en_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == REG_POLL_MASK) begin
        poll_match_mask <= reg_wdata;
      end
    end
  end

  // sticky status, set beats the clear by a start
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      halted_reg <= 1'b0;
      poll_hit_reg <= 1'b0;
    end else if (ce) begin
      if (st_reg == S_DECIDE && !retry_go && ctl_reg[CW_EOL_BIT]) begin
        halted_reg <= 1'b1;
      end else if (start_req && st_reg == S_IDLE) begin
        halted_reg <= 1'b0;
      end
      if (poll_now) begin
        poll_hit_reg <= 1'b1;
      end else if (start_req && st_reg == S_IDLE) begin
        poll_hit_reg <= 1'b0;
      end
    end
  end

  // read data a cycle on, unmapped reads zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
    end else if (ce) begin
      if (reg_rd) begin
        case (reg_addr)
          REG_CTRL: rdata_reg <= ctrl_reg | {15'h0000, st_reg != S_IDLE};
          REG_CUR_BLK: rdata_reg <= cur_blk_reg;
          REG_HP_EN: rdata_reg <= hp_en_reg;
          REG_STD_EN: rdata_reg <= std_en_reg;
          REG_POLL_MASK: rdata_reg <= poll_match_mask;
          REG_STATUS: rdata_reg <= {8'h00, bus_sel_reg, tries_reg, err_reg,
                                    poll_hit_reg, halted_reg, st_reg != S_IDLE};
          default: rdata_reg <= 16'h0000;
        endcase
      end
    end
  end
  assign reg_rdata = rdata_reg;
endmodule : mbc_sequencer

// File: verification/mbc_monitor.sv
`timescale 1ns/1ps
module mbc_monitor import mbc_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // dma
  input wire logic dma_req,
  input wire logic dma_we,
  input wire logic dma_burst,
  input wire logic [15:0] dma_addr,
  input wire logic [15:0] dma_wdata,
  input wire logic dma_ack,
  input wire logic [15:0] dma_rdata,
  // 1553 side
  input wire logic tx_valid,
  input wire logic tx_is_cmd,
  input wire logic [15:0] tx_word,
  input wire logic tx_done,
  input wire logic rx_valid,
  input wire logic [15:0] rx_word,
  input wire logic rx_is_status,
  // interrupts
  input wire logic standard_irq_n,
  input wire logic high_priority_irq_n
);
  logic [7:0] gap_cnt;
  logic [15:0] last_sts;
  logic [15:0] last_rd;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // bus quiet time, saturating
  always_ff @(posedge clock) begin
    if (!rst_n) gap_cnt <= 8'hff;
    else if (rx_valid) gap_cnt <= 8'h00;
    else if (gap_cnt != 8'hff) gap_cnt <= gap_cnt + 8'h01;
  end
  // last status and fetched word
  always_ff @(posedge clock) begin
    if (rx_valid && rx_is_status) last_sts <= rx_word;
    if (dma_req && dma_ack && !dma_we && !dma_burst) last_rd <= dma_rdata;
  end
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=>
    !dma_req && !tx_valid && standard_irq_n && high_priority_irq_n) else $error("busy in reset");
  a_dma_steady: assert property (dma_req && !dma_ack |=> dma_req &&
    $stable(dma_addr) && $stable(dma_we) && $stable(dma_wdata)) else $error("dma dropped");
  a_tx_steady: assert property (tx_valid && !tx_done |=>
    tx_valid && $stable(tx_word)) else $error("tx dropped");
  a_std_pulse: assert property (!standard_irq_n |=> standard_irq_n)
    else $error("std irq long");
  a_hp_pulse: assert property (!high_priority_irq_n |=> high_priority_irq_n)
    else $error("hp irq long");
  a_gap_min: assert property ($rose(tx_valid) && tx_is_cmd |->
    gap_cnt >= MIN_GAP_CYC) else $error("gap short");
  a_sts_stored: assert property (rx_valid && rx_is_status |=>
    ##[0:40] (dma_req && dma_we && dma_wdata == last_sts)) else $error("status not stored");
  a_data_fetched: assert property ($rose(tx_valid) && !tx_is_cmd |->
    tx_word == last_rd) else $error("data not from ram");
  c_std: cover property (!standard_irq_n);
  c_hp: cover property (!high_priority_irq_n);
  c_err: cover property (dma_req && dma_we && dma_burst && dma_wdata[15]);
endmodule : mbc_monitor

bind mbc_sequencer mbc_monitor i_mon (.*);

// File: verification/mbc_partner.sv
`timescale 1ns/1ps
module mbc_partner (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // knobs
  input wire logic slow,
  input wire logic bad_addr,
  input wire logic [15:0] sts_or,
  output logic hit0,
  output logic [15:0] last_data,
  // ram
  input wire logic dma_req,
  input wire logic dma_we,
  input wire logic [15:0] dma_addr,
  input wire logic [15:0] dma_wdata,
  output logic dma_ack,
  output logic [15:0] dma_rdata,
  // remote terminal
  input wire logic tx_valid,
  input wire logic tx_is_cmd,
  input wire logic [15:0] tx_word,
  output logic tx_done,
  output logic rx_valid,
  output logic [15:0] rx_word,
  output logic rx_is_status
);
  logic [15:0] mem [0:255];
  logic [16:0] q [$];
  logic [15:0] sts_reg;
  logic [5:0] rcnt;
  logic [5:0] wc;
  logic [1:0] pace = 2'h0;
  assign wc = (tx_word[4:0] == 5'h00) ? 6'h20 : {1'b0, tx_word[4:0]};
  initial {hit0, dma_ack, dma_rdata, tx_done, rx_valid, rx_word, rx_is_status} = '0;
  // status, address flipped on request
  function automatic logic [15:0] sts_of(input logic [15:0] c);
    sts_of = {c[15:11] ^ {4'h0, bad_addr}, 11'h000} | sts_or;
  endfunction : sts_of
  // idle lines toggle, stale data never looks valid
  always @(posedge clock) begin
    pace <= pace + 2'h1;
    tx_done <= tx_valid && !tx_done;
    rx_valid <= 1'b0;
    rx_word <= ~rx_word;
    dma_ack <= 1'b0;
    dma_rdata <= ~dma_rdata;
    if (!rst_n) begin
      q.delete();
      rcnt <= 6'h00;
    end else begin
      if (dma_req && !dma_ack && (!slow || pace == 2'h3)) begin
        dma_ack <= 1'b1;
        dma_rdata <= mem[dma_addr[7:0]];
      end
      if (dma_req && dma_ack && dma_we) mem[dma_addr[7:0]] <= dma_wdata;
      if (dma_req && dma_ack && dma_addr[2:0] == 3'h0 && dma_addr < 16'h0040) hit0 <= 1'b1;
      if (tx_valid && tx_done && tx_is_cmd && tx_word[10]) begin
        q.push_back({1'b1, sts_of(tx_word)});
        for (int i = 0; i < wc; i++) q.push_back({1'b0, 16'hd000 + 16'(i)});
      end else if (tx_valid && tx_done && tx_is_cmd) begin
        rcnt <= wc;
        sts_reg <= sts_of(tx_word);
      end else if (tx_valid && tx_done) begin
        last_data <= tx_word;
        rcnt <= rcnt - 6'h01;
        if (rcnt == 6'h01) q.push_back({1'b1, sts_reg});
      end
      if (q.size() > 0 && pace == 2'h3 && !dma_req) begin
        {rx_is_status, rx_word} <= q.pop_front();
        rx_valid <= 1'b1;
      end
    end
  end
endmodule : mbc_partner

// File: verification/mbc_sequencer_tb.sv
`timescale 1ns/1ps
module mbc_sequencer_tb import mbc_pkg::*; ();
  logic clock = 1'b0, rst_n = 1'b0, ce = 1'b1, rx_error = 1'b0, reg_wr = 1'b0;
  logic reg_rd = 1'b0, slow = 1'b0, bad_addr = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] sts_or = 16'h0000;
  logic dma_req, dma_we, dma_burst, dma_ack, tx_valid, tx_is_cmd, tx_done, rx_valid;
  logic rx_is_status, standard_irq_n, high_priority_irq_n, hit0;
  logic [15:0] dma_addr, dma_wdata, dma_rdata, tx_word, rx_word, reg_rdata, last_data, rd_val;
  int errors, n_tests, std_cnt, hp_cnt, cyc, t_std, t_tx;
  mbc_sequencer i_dut (.bus_select(), .*);
  mbc_partner i_far (.*);
  initial forever #10 clock = ~clock;
  // irq and message starts
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (!standard_irq_n) std_cnt <= std_cnt + 1;
    if (!standard_irq_n) t_std <= cyc;
    if (!high_priority_irq_n) hp_cnt <= hp_cnt + 1;
    if ($rose(tx_valid)) t_tx <= cyc;
  end
  task automatic chk(input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd
  // one block, tail sixteen words on
  task automatic blk(input logic [7:0] a, input logic [15:0] ctl, cmd, dp);
    i_far.mem[a] = 16'hbeef;
    i_far.mem[a + 1] = ctl;
    i_far.mem[a + 2] = cmd;
    i_far.mem[a + 4] = dp;
    i_far.mem[a + 5] = 16'hffff;
    i_far.mem[a + 8'h07] = {8'h00, a + 8'h10};
  endtask : blk
  // run a list up to its end-of-list pulse
  task automatic go(input logic [15:0] b, std_en, mask);
    int h = hp_cnt;
    wr(REG_HP_EN, 16'h0001);
    wr(REG_STD_EN, std_en);
    wr(REG_POLL_MASK, mask);
    wr(REG_CUR_BLK, b);
    wr(REG_CTRL, 16'h0001);
    for (int i = 0; i < 4000 && hp_cnt == h; i++) @(posedge clock);
    repeat (4) @(posedge clock);
    chk(16'(hp_cnt - h), 16'h0001);
    rd(REG_STATUS);
    chk(rd_val & 16'h0003, 16'h0002);
  endtask : go
  task automatic t_poll;
    int s = std_cnt;
    blk(8'h10, 16'h1400, 16'h1822, 16'h0041);
    i_far.mem[8'h41] = 16'ha5a5;
    i_far.mem[8'h42] = 16'h5a5a;
    sts_or <= 16'h0004;
    go(16'h0010, 16'h0002, 16'h0004);
    chk(i_far.mem[8'h15], 16'h1804);
    chk(i_far.mem[8'h11], 16'h1400);
    chk(last_data, 16'h5a5a);
    chk(16'(std_cnt - s), 16'h0001);
    $display("poll done");
  endtask : t_poll
  // skip with delay, slow-ram receive
  task automatic t_skip;
    int s = std_cnt;
    blk(8'h20, 16'h6001, 16'h0000, 16'h0000);
    blk(8'h30, 16'h0400, 16'h2c22, 16'h0051);
    slow <= 1'b1;
    sts_or <= 16'h0000;
    go(16'h0020, 16'h0003, 16'h0000);
    chk(i_far.mem[8'h25], 16'hffff);
    chk(i_far.mem[8'h35], 16'h2800);
    chk(i_far.mem[8'h51], 16'hd000);
    chk(i_far.mem[8'h52], 16'hd001);
    chk(16'(std_cnt - s), 16'h0001);
    chk(16'((t_tx - t_std) inside {[DELAY_UNIT_CYC - 40 : DELAY_UNIT_CYC + 40]}), 16'h0001);
    rd(REG_CUR_BLK);
    chk(rd_val, 16'h0030);
    $display("skip done");
  endtask : t_skip
  task automatic t_err;
    blk(8'h10, 16'h0400, 16'h1821, 16'h0041);
    slow <= 1'b0;
    bad_addr <= 1'b1;
    go(16'h0010, 16'h0000, 16'h0000);
    chk(i_far.mem[8'h11], 16'h8400);
    $display("error done");
  endtask : t_err
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    t_poll;
    t_skip;
    t_err;
    chk(16'(hit0), 16'h0000);
    report_and_stop;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    report_and_stop;
  end
endmodule : mbc_sequencer_tb
